/* File: nsc_consts.svh */
`ifndef NSC_CONSTS_SVH
`define NSC_CONSTS_SVH
// System clock rate in kHz and the common timing tick period in microseconds
`define NSC_CLK_KHZ 40000
`define NSC_TICK_US 1000
`define NSC_TICK_CYCLES ((`NSC_TICK_US * `NSC_CLK_KHZ) / 1000)
// Full scale of a duty or percentage value
`define NSC_PCT_FULL 8'h64
// Reset values
`define NSC_CNT_RST 16'h0000
`define NSC_SYNC_RST 3'h0
`define NSC_PW_RST 16'h0000
`define NSC_PIN_RST 8'h00
// Number of assignable solenoid output pins
`define NSC_PIN_NUM 8
`endif

/* File: nsc_pkg.sv */
package nsc_pkg;
    typedef enum logic {NSC_MODE_ONOFF = 1'b0, NSC_MODE_PROG = 1'b1} nsc_mode_t;
    typedef enum logic [1:0] {
        NSC_AX_TIME = 2'b00, NSC_AX_RPM = 2'b01, NSC_AX_VSS = 2'b10
    } nsc_axis_t;
    typedef enum logic [1:0] {
        NSC_BANK_BOTH = 2'b00, NSC_BANK_1 = 2'b01, NSC_BANK_2 = 2'b10
    } nsc_bank_t;
    typedef enum logic {NSC_PEDAL_RESTART = 1'b0, NSC_PEDAL_RESUME = 1'b1} nsc_pedal_t;
    typedef enum logic {NSC_FSRC_DUTY = 1'b0, NSC_FSRC_TABLE = 1'b1} nsc_fsrc_t;
    typedef enum logic [1:0] {
        NSC_ST_OFF = 2'b00, NSC_ST_RUN = 2'b01, NSC_ST_LIFT = 2'b10
    } nsc_state_t;
    typedef struct packed {
        logic [15:0] rpm;
        logic [11:0] clt;
        logic [9:0] tps;
        logic [11:0] map;
        logic [11:0] vss;
    } nsc_sens_t;
    typedef struct packed {
        logic enable;
        nsc_mode_t mode;
        nsc_axis_t axis;
        nsc_bank_t bank;
        nsc_pedal_t pedal;
        nsc_fsrc_t fsrc;
        logic alt_sel;
        logic allow_launch;
        logic [15:0] rpm_min;
        logic [15:0] rpm_max;
        logic [11:0] clt_min;
        logic [9:0] tps_min;
        logic [11:0] map_launch_max;
        logic [15:0] pedal_to;
        logic [15:0] launch_dly;
        logic [15:0] shift_dly;
        logic [15:0] nos_period;
        logic [15:0] fuel_period;
        logic [15:0] pw_min;
        logic [15:0] pw_max;
        logic [7:0] retard;
        logic [2:0] nos_pin;
        logic [2:0] fuel_pin;
    } nsc_cfg_t;
endpackage

/* File: nsc_sensor_model.sv */
module nsc_sensor_model
    import nsc_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Requested engine state
    input wire nsc_sens_t sens_req_in,
    input wire logic arm_req_in,
    // Lines into the controller
    output nsc_sens_t sens_out,
    output logic arm_pin_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sens_out = '0;
        arm_pin_out = 1'b0;
    end
    // Sensor readings settle a little after the edge that samples the request
    always @(posedge clk_in) sens_out <= #2 sens_req_in;
    // The arming switch is not tied to the clock, so it moves off the clock grid
    always @(arm_req_in) arm_pin_out <= #7 arm_req_in;
endmodule

/* File: nsc_stage_ctrl.sv */
`include "nsc_consts.svh"
module nsc_stage_ctrl
    import nsc_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `NSC_TICK_CYCLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Configuration and sensors
    input wire nsc_cfg_t cfg_in,
    input wire nsc_sens_t sens_in,
    // Arming pin and engine events
    input wire logic arm_pin_in,
    input wire logic launch_in,
    input wire logic flat_shift_in,
    // Curve table answers and base spark
    input wire logic [7:0] duty_in,
    input wire logic [7:0] fuel_pct_in,
    input wire logic signed [11:0] spark_base_in,
    // Solenoid outputs
    output logic [`NSC_PIN_NUM-1:0] pins_out,
    output logic nos_on_out,
    output logic fuel_on_out,
    // Status and engine corrections
    output logic active_out,
    output logic [15:0] axis_val_out,
    output logic [15:0] prog_timer_out,
    output logic [15:0] fuel_bank1_out,
    output logic [15:0] fuel_bank2_out,
    output logic [7:0] retard_out,
    output logic signed [11:0] spark_out,
    output logic alt_targets_out
);
    function automatic logic [15:0] dec_tick(input logic [15:0] cnt, input logic tk);
        dec_tick = (tk && cnt != 16'h0000) ? cnt - 16'h0001 : cnt;
    endfunction

    function automatic logic [15:0] pwm_step(input logic [15:0] cnt, input logic [15:0] per);
        pwm_step = (cnt + 16'h0001 >= per) ? 16'h0000 : cnt + 16'h0001;
    endfunction

    function automatic logic pwm_high(input logic [15:0] cnt, input logic [15:0] per,
                                      input logic [7:0] duty);
        pwm_high = (24'(cnt) * 24'(`NSC_PCT_FULL)) < (24'(duty) * 24'(per));
    endfunction

    function automatic logic [7:0] pin_onehot(input logic [2:0] sel);
        pin_onehot = 8'h01 << sel;
    endfunction

    logic [15:0] tick_cnt_reg;
    logic [2:0] arm_sync_reg;
    logic arm_reg;
    logic launch_prev_reg, shift_prev_reg;
    logic [15:0] launch_hold_reg, shift_hold_reg, pedal_cnt_reg;
    logic [15:0] prog_timer_reg, prog_timer_next;
    logic [15:0] nos_pwm_reg, fuel_pwm_reg;
    nsc_state_t state_reg, state_next;
    logic nos_on_reg, fuel_on_reg, active_reg, alt_reg;
    logic [15:0] axis_reg, bank1_reg, bank2_reg;
    logic [7:0] retard_reg;
    logic [7:0] pins_reg;

    // Common timing tick
    wire tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));

    // Activation conditions
    wire rpm_ok = sens_in.rpm > cfg_in.rpm_min;
    wire clt_ok = sens_in.clt > cfg_in.clt_min;
    wire tps_ok = sens_in.tps > cfg_in.tps_min;
    wire rpm_over = sens_in.rpm > cfg_in.rpm_max;
    wire map_over = sens_in.map > cfg_in.map_launch_max;
    wire launch_block = launch_in && (!cfg_in.allow_launch || map_over);
    wire launch_fell = launch_prev_reg && !launch_in;
    wire shift_fell = shift_prev_reg && !flat_shift_in;
    wire launch_hold = launch_fell || launch_hold_reg != 16'h0000;
    wire shift_hold = shift_fell || shift_hold_reg != 16'h0000;
    wire armed = cfg_in.enable && arm_reg;
    wire others_ok = armed && rpm_ok && clt_ok && !rpm_over && !launch_block
                     && !launch_hold && !shift_hold;
    wire permit = others_ok && tps_ok;
    wire prog = cfg_in.mode == NSC_MODE_PROG;
    wire lift = others_ok && !tps_ok && prog;

    // Progressive timer and throttle lift handling
    always_comb begin
        state_next = state_reg;
        prog_timer_next = prog_timer_reg;
        unique case (state_reg)
            NSC_ST_OFF: begin
                prog_timer_next = 16'h0000;
                if (permit) begin
                    state_next = NSC_ST_RUN;
                end
            end
            NSC_ST_RUN: begin
                if (permit) begin
                    if (tick && prog_timer_reg != 16'hFFFF) begin
                        prog_timer_next = prog_timer_reg + 16'h0001;
                    end
                end else if (lift) begin
                    state_next = NSC_ST_LIFT;
                end else begin
                    state_next = NSC_ST_OFF;
                    prog_timer_next = 16'h0000;
                end
            end
            NSC_ST_LIFT: begin
                if (permit) begin
                    state_next = NSC_ST_RUN;
                    if (cfg_in.pedal == NSC_PEDAL_RESTART) begin
                        prog_timer_next = 16'h0000;
                    end
                end else if (!lift || pedal_cnt_reg == 16'h0000) begin
                    state_next = NSC_ST_OFF;
                    prog_timer_next = 16'h0000;
                end
            end
            default: begin
                state_next = NSC_ST_OFF;
                prog_timer_next = 16'h0000;
            end
        endcase
    end

    wire run_next = state_next == NSC_ST_RUN;

    // Solenoid modulation
    wire nos_pwm_hi = pwm_high(nos_pwm_reg, cfg_in.nos_period, duty_in);
    wire fuel_pwm_hi = pwm_high(fuel_pwm_reg, cfg_in.fuel_period, duty_in);
    wire nos_next = run_next && (!prog || nos_pwm_hi);
    wire fuel_next = run_next && (!prog || fuel_pwm_hi);
    wire [7:0] pins_next = (nos_next ? pin_onehot(cfg_in.nos_pin) : 8'h00)
                           | (fuel_next ? pin_onehot(cfg_in.fuel_pin) : 8'h00);

    // Lookup axis for the progressive curve
    wire [15:0] axis_next = (cfg_in.axis == NSC_AX_RPM) ? sens_in.rpm :
                            (cfg_in.axis == NSC_AX_VSS) ? {4'h0, sens_in.vss} :
                            prog_timer_next;

    // Added fuel interpolated between the two engine-speed points
    wire [15:0] rpm_span = cfg_in.rpm_max - cfg_in.rpm_min;
    wire [15:0] rpm_off = (sens_in.rpm <= cfg_in.rpm_min) ? 16'h0000 :
                          (sens_in.rpm >= cfg_in.rpm_max) ? rpm_span :
                          sens_in.rpm - cfg_in.rpm_min;
    wire pw_up = cfg_in.pw_max >= cfg_in.pw_min;
    wire [15:0] pw_dif = pw_up ? cfg_in.pw_max - cfg_in.pw_min : cfg_in.pw_min - cfg_in.pw_max;
    wire [31:0] pw_prod = 32'(pw_dif) * 32'(rpm_off);
    wire [15:0] pw_step = (rpm_span == 16'h0000) ? 16'h0000 : 16'(pw_prod / 32'(rpm_span));
    wire [15:0] pw_interp = pw_up ? cfg_in.pw_min + pw_step
                                  : cfg_in.pw_min - pw_step;
    wire scale_on = prog && cfg_in.axis != NSC_AX_RPM;
    wire [7:0] pct = (cfg_in.fsrc == NSC_FSRC_TABLE) ? fuel_pct_in : duty_in;
    wire [15:0] pw_scaled = 16'((32'(pw_interp) * 32'(pct)) / 32'(`NSC_PCT_FULL));
    wire [15:0] pw_add = !run_next ? `NSC_PW_RST :
                         scale_on ? pw_scaled : pw_interp;
    wire [15:0] bank1_next = (cfg_in.bank != NSC_BANK_2) ? pw_add : `NSC_PW_RST;
    wire [15:0] bank2_next = (cfg_in.bank != NSC_BANK_1) ? pw_add : `NSC_PW_RST;
    wire [7:0] retard_next = (run_next && !prog) ? cfg_in.retard : 8'h00;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tick_cnt_reg <= `NSC_CNT_RST;
            arm_sync_reg <= `NSC_SYNC_RST;
            arm_reg <= 1'b0;
            launch_prev_reg <= 1'b0;
            shift_prev_reg <= 1'b0;
        end else begin
            tick_cnt_reg <= tick ? `NSC_CNT_RST : tick_cnt_reg + 16'h0001;
            arm_sync_reg <= {arm_sync_reg[1:0], arm_pin_in};
            if (arm_sync_reg[2] == arm_sync_reg[1]) begin
                arm_reg <= arm_sync_reg[2];
            end
            launch_prev_reg <= launch_in;
            shift_prev_reg <= flat_shift_in;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            launch_hold_reg <= `NSC_CNT_RST;
            shift_hold_reg <= `NSC_CNT_RST;
            pedal_cnt_reg <= `NSC_CNT_RST;
        end else begin
            launch_hold_reg <= launch_fell ? cfg_in.launch_dly
                                           : dec_tick(launch_hold_reg, tick);
            shift_hold_reg <= shift_fell ? cfg_in.shift_dly
                                         : dec_tick(shift_hold_reg, tick);
            pedal_cnt_reg <= (state_reg != NSC_ST_LIFT) ? cfg_in.pedal_to
                                                        : dec_tick(pedal_cnt_reg, tick);
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= NSC_ST_OFF;
            prog_timer_reg <= `NSC_CNT_RST;
            nos_pwm_reg <= `NSC_CNT_RST;
            fuel_pwm_reg <= `NSC_CNT_RST;
        end else begin
            state_reg <= state_next;
            prog_timer_reg <= prog_timer_next;
            nos_pwm_reg <= pwm_step(nos_pwm_reg, cfg_in.nos_period);
            fuel_pwm_reg <= pwm_step(fuel_pwm_reg, cfg_in.fuel_period);
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            nos_on_reg <= 1'b0;
            fuel_on_reg <= 1'b0;
            pins_reg <= `NSC_PIN_RST;
            active_reg <= 1'b0;
            alt_reg <= 1'b0;
            axis_reg <= `NSC_CNT_RST;
            bank1_reg <= `NSC_PW_RST;
            bank2_reg <= `NSC_PW_RST;
            retard_reg <= 8'h00;
        end else begin
            nos_on_reg <= nos_next;
            fuel_on_reg <= fuel_next;
            pins_reg <= pins_next;
            active_reg <= run_next;
            alt_reg <= run_next && cfg_in.alt_sel;
            axis_reg <= axis_next;
            bank1_reg <= bank1_next;
            bank2_reg <= bank2_next;
            retard_reg <= retard_next;
        end
    end

    assign pins_out = pins_reg;
    assign nos_on_out = nos_on_reg;
    assign fuel_on_out = fuel_on_reg;
    assign active_out = active_reg;
    assign alt_targets_out = alt_reg;
    assign axis_val_out = axis_reg;
    assign prog_timer_out = prog_timer_reg;
    assign fuel_bank1_out = bank1_reg;
    assign fuel_bank2_out = bank2_reg;
    assign retard_out = retard_reg;
    assign spark_out = spark_base_in - $signed({4'h0, retard_reg});

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);

    a_enable_off_quiet: assert property (!cfg_in.enable |=> !nos_on_out
        && !fuel_on_out && pins_out == 8'h00 && fuel_bank1_out == 16'h0000 && retard_out == 8'h00)
        else $error("outputs active with enable off");
    a_rpm_min_gate: assert property (sens_in.rpm <= cfg_in.rpm_min |=> !active_out)
        else $error("active below minimum rpm");
    a_clt_min_gate: assert property (sens_in.clt <= cfg_in.clt_min |=> !active_out)
        else $error("active below minimum coolant");
    a_tps_min_gate: assert property (!tps_ok |=> !nos_on_out)
        else $error("nitrous on below minimum throttle");
    a_rpm_max_cut: assert property (rpm_over |=> !active_out && !nos_on_out)
        else $error("active above maximum rpm");
    a_bank_one_only: assert property (cfg_in.bank == NSC_BANK_1
        |=> fuel_bank2_out == 16'h0000)
        else $error("bank 2 fuel while bank 1 selected");
    a_onoff_solid: assert property (run_next && !prog |=> nos_on_out && fuel_on_out)
        else $error("on/off solenoid not solid");
    a_prog_zero_duty: assert property (prog && duty_in == 8'h00
        |=> !nos_on_out && !fuel_on_out)
        else $error("solenoid on at zero duty");
    a_lift_restart: assert property (state_reg == NSC_ST_LIFT && run_next
        && cfg_in.pedal == NSC_PEDAL_RESTART |=> prog_timer_out == 16'h0000)
        else $error("timer kept after restart lift");
    a_lift_resume: assert property (state_reg == NSC_ST_LIFT && run_next
        && cfg_in.pedal == NSC_PEDAL_RESUME |=> prog_timer_out == $past(prog_timer_reg))
        else $error("timer lost on resume");
    a_alt_targets: assert property (alt_targets_out
        |-> active_out && $past(cfg_in.alt_sel))
        else $error("alternate targets without nitrous");
    a_arm_needed: assert property (!arm_reg |=> !active_out)
        else $error("active while disarmed");
    a_retard_value: assert property (run_next && !prog
        |=> retard_out == $past(cfg_in.retard))
        else $error("retard not applied");
    a_launch_hold: assert property (launch_fell && cfg_in.launch_dly != 16'h0000
        |-> ##1 !active_out ##1 !active_out)
        else $error("nitrous during launch hold");
    a_shift_hold: assert property (shift_fell |=> !active_out)
        else $error("nitrous right after flat shift");
    a_launch_map: assert property (launch_in && map_over |=> !active_out)
        else $error("nitrous over launch map limit");

    c_onoff_run: cover property (!prog && active_out ##1 nos_on_out);
    c_prog_resume: cover property (state_reg == NSC_ST_LIFT ##1 state_reg == NSC_ST_RUN);
    c_launch_hold: cover property (launch_fell ##1 launch_hold_reg != 16'h0000);
    c_pwm_toggle: cover property (prog && nos_on_out ##1 !nos_on_out);
endmodule

/* File: test_nitrous_stage_controller.sv */
module test_nitrous_stage_controller;
    timeunit 1ns;
    timeprecision 100ps;
    import nsc_pkg::*;
    localparam int TICKS = 4;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    nsc_cfg_t cfg;
    nsc_sens_t sens_req;
    nsc_sens_t sens;
    logic arm_req, arm_pin, launch, flat_shift, on_x, pn, pf;
    logic [7:0] duty, fpct, pins_out, retard_out;
    logic signed [11:0] spark_base, spark_out;
    logic nos_on_out, fuel_on_out, active_out, alt_targets_out;
    logic [15:0] axis_val_out, prog_timer_out, fuel_bank1_out, fuel_bank2_out, t0;
    logic [15:0] rpm_tab [4] = '{16'h03E8, 16'h03E9, 16'h1770, 16'h1771};
    logic [31:0] r;
    int n_errors = 0;
    int total_checks = 0;
    int seed = 32'h5FCEEE12;
    int hi_n, hi_f, up_n, up_f;

    always #12.5 clk_in = ~clk_in;

    nsc_sensor_model u_nsc_sensor_model (.clk_in(clk_in), .sens_req_in(sens_req),
        .arm_req_in(arm_req), .sens_out(sens), .arm_pin_out(arm_pin));

    nsc_stage_ctrl #(.TICK_CYCLES(TICKS)) u_nsc_stage_ctrl (.clk_in(clk_in), .rstn_in(rstn_in),
        .cfg_in(cfg), .sens_in(sens), .arm_pin_in(arm_pin), .launch_in(launch),
        .flat_shift_in(flat_shift), .duty_in(duty), .fuel_pct_in(fpct),
        .spark_base_in(spark_base), .pins_out(pins_out), .nos_on_out(nos_on_out),
        .fuel_on_out(fuel_on_out), .active_out(active_out), .axis_val_out(axis_val_out),
        .prog_timer_out(prog_timer_out), .fuel_bank1_out(fuel_bank1_out),
        .fuel_bank2_out(fuel_bank2_out), .retard_out(retard_out), .spark_out(spark_out),
        .alt_targets_out(alt_targets_out));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #2;
    endtask

    task automatic wrap_up();
        $display("Errors: %0d, checks: %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    function automatic logic exp_on();
        return cfg.enable && arm_req && sens_req.rpm > cfg.rpm_min && sens_req.clt > cfg.clt_min
            && sens_req.tps > cfg.tps_min && sens_req.rpm <= cfg.rpm_max;
    endfunction

    function automatic logic [15:0] exp_pw();
        logic [31:0] pw;
        pw = cfg.pw_min + ((cfg.pw_max - cfg.pw_min) * (sens_req.rpm - cfg.rpm_min))
            / (cfg.rpm_max - cfg.rpm_min);
        if (cfg.mode == NSC_MODE_PROG && cfg.axis != NSC_AX_RPM) begin
            pw = pw * ((cfg.fsrc == NSC_FSRC_TABLE) ? fpct : duty) / 100;
        end
        return exp_on() ? pw[15:0] : 16'h0000;
    endfunction

    task automatic check_outs();
        logic on;
        logic [15:0] pw;
        logic [7:0] pv;
        logic [11:0] sp;
        on = exp_on();
        pw = exp_pw();
        pv = on ? (8'h01 << cfg.nos_pin) | (8'h01 << cfg.fuel_pin) : 8'h00;
        sp = 12'(spark_base - (on ? cfg.retard : 8'h00));
        check(32'(active_out), 32'(on));
        check(32'(nos_on_out), 32'(on));
        check(32'(fuel_on_out), 32'(on));
        check(32'(pins_out), 32'(pv));
        check(32'(fuel_bank1_out), cfg.bank != NSC_BANK_2 ? 32'(pw) : 32'h0);
        check(32'(fuel_bank2_out), 32'(cfg.bank != NSC_BANK_1 ? pw : 16'h0000));
        check(32'(retard_out), 32'(on ? cfg.retard : 8'h00));
        check({20'h0, spark_out}, {20'h0, sp});
        check(32'(alt_targets_out), 32'(on & cfg.alt_sel));
    endtask

    task automatic good();
        sens_req = '{rpm: 16'h0BB8, clt: 12'h0C8, tps: 10'h200, map: 12'h064, vss: 12'h123};
        cfg.enable = 1'b1;
        cfg.bank = NSC_BANK_BOTH;
        arm_req = 1'b1;
    endtask

    initial begin
        repeat (5000) @(posedge clk_in);
        n_errors++;
        wrap_up();
    end

    initial begin
        cfg = '0;
        cfg.rpm_min = 16'h03E8;
        cfg.rpm_max = 16'h1770;
        cfg.clt_min = 12'h064;
        cfg.tps_min = 10'h064;
        cfg.map_launch_max = 12'h0C8;
        cfg.pedal_to = 16'h000A;
        cfg.launch_dly = 16'h0005;
        cfg.shift_dly = 16'h0003;
        cfg.nos_period = 16'h000A;
        cfg.fuel_period = 16'h0014;
        cfg.pw_min = 16'h0064;
        cfg.pw_max = 16'h0258;
        sens_req = '0;
        {arm_req, launch, flat_shift} = 3'h0;
        duty = 8'h32;
        fpct = 8'h4B;
        spark_base = 12'sh0C8;
        step(3);
        check(32'(active_out), 32'h0);
        check(32'(pins_out), 32'h0);
        step(3);
        rstn_in = 1'b1;
        for (int i = 0; i < 60; i++) begin
            r = $random(seed);
            good();
            if (i < 4) sens_req.rpm = rpm_tab[i];
            if (i == 4) sens_req.clt = cfg.clt_min;
            if (i == 5) sens_req.tps = cfg.tps_min;
            if (i >= 6) begin
                sens_req = '{rpm: {3'h0, r[12:0]}, clt: {4'h0, r[20:13]}, tps: {1'b0, r[29:21]},
                    map: 12'h064, vss: 12'h0};
                cfg.enable = !(r[30] & r[31]);
                arm_req = !(r[27] & r[26]);
            end
            cfg.bank = nsc_bank_t'(2'(i % 3));
            cfg.alt_sel = r[0];
            cfg.retard = r[7:0];
            cfg.nos_pin = 3'(i);
            cfg.fuel_pin = r[10:8];
            spark_base = 12'(r[11:0]);
            step(8);
            check_outs();
        end
        good();
        for (int i = 0; i < 3; i++) begin
            cfg.allow_launch = (i > 0);
            sens_req.map = (i == 1) ? 12'h12C : 12'h064;
            launch = 1'b1;
            step(8);
            check(32'(active_out), 32'(i == 2));
        end
        launch = 1'b0;
        step(4);
        check(32'(active_out), 32'h0);
        step(30);
        check(32'(active_out), 32'h1);
        flat_shift = 1'b1;
        step(3);
        flat_shift = 1'b0;
        step(4);
        check(32'(active_out), 32'h0);
        step(30);
        check(32'(active_out), 32'h1);
        cfg.mode = NSC_MODE_PROG;
        cfg.axis = NSC_AX_TIME;
        cfg.fsrc = NSC_FSRC_TABLE;
        step(10);
        {hi_n, hi_f, up_n, up_f} = '0;
        pn = nos_on_out;
        pf = fuel_on_out;
        for (int k = 0; k < 100; k++) begin
            step(1);
            hi_n += int'(nos_on_out);
            hi_f += int'(fuel_on_out);
            up_n += int'(nos_on_out & !pn);
            up_f += int'(fuel_on_out & !pf);
            pn = nos_on_out;
            pf = fuel_on_out;
        end
        check(32'(hi_n), 32'd50);
        check(32'(up_n), 32'd10);
        check(32'(hi_f), 32'd50);
        check(32'(up_f), 32'd5);
        check(32'(retard_out), 32'h0);
        check(32'(fuel_bank1_out), 32'(exp_pw()));
        duty = 8'h00;
        step(3);
        check(32'(nos_on_out), 32'h0);
        check(32'(fuel_on_out), 32'h0);
        duty = 8'h32;
        cfg.fsrc = NSC_FSRC_DUTY;
        step(3);
        check(32'(fuel_bank2_out), 32'(exp_pw()));
        for (int a = 1; a < 3; a++) begin
            cfg.axis = nsc_axis_t'(2'(a));
            step(3);
            t0 = (a == 1) ? sens_req.rpm : {4'h0, sens_req.vss};
            check(32'(axis_val_out), 32'(t0));
            check(32'(fuel_bank1_out), 32'(exp_pw()));
        end
        cfg.axis = NSC_AX_TIME;
        for (int p = 0; p < 2; p++) begin
            cfg.pedal = nsc_pedal_t'(p[0]);
            step(40);
            t0 = prog_timer_out;
            check(32'(axis_val_out), 32'(t0));
            sens_req.tps = 10'h000;
            step(12);
            check(32'(active_out), 32'h0);
            sens_req.tps = 10'h200;
            step(3);
            on_x = (p == 1) ? (prog_timer_out >= t0) : (prog_timer_out <= 16'h0001);
            check(32'(on_x), 32'h1);
        end
        step(20);
        sens_req.tps = 10'h000;
        step(60);
        check(32'(prog_timer_out), 32'h0);
        check(32'(nos_on_out), 32'h0);
        wrap_up();
    end
endmodule
